//--- dv/buck_plant.sv
// Behavioural power stage, output node and threshold comparators.
module buck_plant import buck_sup_pkg::*; (
    // Clock and stage drive.
    input  wire logic        i_clk,
    input  wire logic        i_hs_on,
    input  wire logic        i_short,
    input  wire comp_flags_t i_force,
    // Open-drain power-good pin.
    input  wire logic        i_pgood_out,
    input  wire logic        i_pgood_oe,
    // Comparator flags and pin level.
    output comp_flags_t      o_flags,
    output logic             o_pgood
);
    timeunit 1ns;
    timeprecision 1ps;
    int v = 70;

    // Output in percent of nominal climbs while the high side conducts.
    always @(posedge i_clk) begin
        if (i_short) begin
            v <= 0;
        end else if (i_hs_on && v < 100) begin
            v <= v + 1;
        end
    end

    always_comb begin
        o_flags               = i_force;
        o_flags.out_above_95  = (v >= 95);
        o_flags.out_below_92  = (v < 92);
        o_flags.out_above_644 = (v >= 65);
        o_flags.fb_low        = (v < 30); // The feedback fault threshold sits well below regulation.
    end

    assign o_pgood = (i_pgood_oe && !i_pgood_out) ? 1'b0 : 1'b1;
endmodule

//--- dv/tb.sv
// Self-checking bench for the converter supervisor.
module tb import buck_sup_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P  = 12;
    localparam int HC = 4;

    typedef struct {
        bit          chk;
        logic [31:0] exp;
        string       nm;
    } note_t;

    logic        i_clk     = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [7:0]  adr       = 8'h00;
    logic [31:0] wdat      = 32'h0;
    logic [3:0]  sel       = 4'h0;
    logic        short_on  = 1'b0;
    logic        seen_sw   = 1'b0;
    comp_flags_t frc       = 12'h012; // Bias good and die cool.
    comp_flags_t flags;
    logic [31:0] o_wb_dat;
    logic [31:0] rdat;
    logic [31:0] r;
    logic        o_wb_ack, o_hs_on, o_ls_on, o_softstart_en, o_pgood_out, o_pgood_oe, o_irq, pgood;
    wire  [2:0]  outs      = {o_pgood_oe, o_ls_on, o_hs_on};
    note_t       q[$];
    note_t       nt;
    int          fails     = 0;
    int          compares  = 0;
    int          hi_cnt    = 0;
    logic [31:0] seed      = 32'h36;

    // Clock at 40 MHz.
    always #12.5 i_clk = ~i_clk;

    buck_fault_hiccup_supervisor #(.HICCUP_COUNT(HC)) u_buck_fault_hiccup_supervisor (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_flags(flags), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_softstart_en(o_softstart_en),
        .i_pgood(pgood), .o_pgood_out(o_pgood_out), .o_pgood_oe(o_pgood_oe), .o_irq(o_irq));

    buck_plant u_buck_plant (
        .i_clk(i_clk), .i_hs_on(o_hs_on), .i_short(short_on), .i_force(frc),
        .i_pgood_out(o_pgood_out), .i_pgood_oe(o_pgood_oe), .o_flags(flags), .o_pgood(pgood));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One classic cycle; a read leaves its expected value for the monitor.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input bit c, input string nm = "");
        if (!w) q.push_back('{c, d, nm});
        @(posedge i_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= w ? d : 32'h0;
        sel  <= 4'hF;
        do begin
            @(posedge i_clk);
        end while (o_wb_ack !== 1'b1);
        rdat = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic poll(input logic [2:0] st, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            wb(ADR_STAT, 1'b0, 32'h0, 1'b0);
            if (rdat[2:0] === st) break;
        end
        check(32'(rdat[2:0]), 32'(st), "state");
    endtask

    task automatic wait_lv(input int b, input logic lv, input int n);
        int k;
        for (k = 0; k < n && outs[b] !== lv; k++) @(posedge i_clk);
        check(32'(outs[b]), 32'(lv), "stage_or_pgood");
    endtask

    // Read answers are paired with the oldest note.
    always @(posedge i_clk) begin
        if (o_wb_ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            nt = q.pop_front();
            if (nt.chk) check(o_wb_dat, nt.exp, nt.nm);
        end
    end

    // Length of the current stretch above 95 percent, and any gate activity.
    always @(posedge i_clk) begin
        hi_cnt <= flags.out_above_95 ? hi_cnt + 1 : 0;
        if (o_hs_on === 1'b1 || o_ls_on === 1'b1) seen_sw <= 1'b1;
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge i_clk);
        check(32'(outs), 32'h4, "reset_outputs");
        i_reset_n <= 1'b1;
        wb(ADR_CTRL, 1'b0, CTRL_RST, 1'b1, "ctrl");
        wb(ADR_IRQMSK, 1'b0, MSK_RST, 1'b1, "mask");
        wb(8'h18, 1'b0, 32'h0, 1'b1, "unmapped");
        wb(ADR_PERIOD, 1'b1, 32'hB, 1'b0);
        wb(ADR_PERIOD, 1'b0, 32'(PERIOD_DEF_CYC), 1'b1, "period");
        wb(ADR_PERIOD, 1'b1, 32'(P), 1'b0);
        wb(ADR_SSLEN, 1'b1, 32'h4, 1'b0);
        wb(ADR_PERIOD, 1'b0, 32'(P), 1'b1, "period");
        repeat (100) @(posedge i_clk);
        check(32'(seen_sw), 32'h0, "prebias_idle");
        frc.pwm_on_req <= 1'b1;
        wait_lv(0, 1'b1, 60);
        wait_lv(1, 1'b1, 60);
        wait_lv(0, 1'b1, 60);
        frc.peak_limit <= 1'b1;
        wait_lv(0, 1'b0, 8);
        frc.peak_limit <= 1'b0;
        poll(3'h2, 2000);
        wait_lv(2, 1'b0, PGOOD_DLY_CYC * P + 400);
        check(32'(hi_cnt >= (PGOOD_DLY_CYC - 1) * P && hi_cnt <= PGOOD_DLY_CYC * P + 200), 32'h1, "pgood_delay");
        check(32'(pgood), 32'h1, "pgood_pin");
        check(32'(o_pgood_out), 32'h0, "pgood_drive");
        wb(ADR_IRQST, 1'b0, 32'h8, 1'b1, "irq_pgood");
        wb(ADR_IRQST, 1'b0, 32'h0, 1'b1, "irq_clear");
        frc.enable_below_falling <= 1'b1;
        wait_lv(2, 1'b1, 10);
        frc.enable_below_falling <= 1'b0;
        wait_lv(2, 1'b0, PGOOD_DLY_CYC * P + 400);
        short_on <= 1'b1;
        wait_lv(2, 1'b1, 10);
        check(32'(pgood), 32'h0, "pgood_pin");
        poll(3'h3, 6000);
        poll(3'h1, 100);
        poll(3'h3, 12000);
        short_on <= 1'b0;
        poll(3'h2, 500);
        r = xs() & 32'hF;
        wb(ADR_IRQMSK, 1'b1, r, 1'b0);
        wb(ADR_IRQMSK, 1'b0, r, 1'b1, "mask");
        wb(ADR_IRQMSK, 1'b1, 32'h1, 1'b0);
        wb(ADR_IRQST, 1'b0, 32'hA, 1'b1, "irq_fb");
        frc.runaway_limit <= 1'b1;
        repeat (4) @(posedge i_clk);
        frc.runaway_limit <= 1'b0;
        poll(3'h3, 20);
        check(32'(o_irq), 32'h1, "irq");
        wb(ADR_IRQST, 1'b0, 32'h1, 1'b1, "irq_run");
        repeat (2) @(posedge i_clk);
        check(32'(o_irq), 32'h0, "irq");
        poll(3'h1, 100);
        poll(3'h2, 500);
        frc.therm_hot  <= 1'b1;
        frc.therm_cool <= 1'b0;
        poll(3'h4, 20);
        check(32'(outs), 32'h4, "stage_off");
        check(32'(o_softstart_en), 32'h0, "softstart");
        check(32'(o_irq), 32'h0, "irq_masked");
        frc.therm_hot  <= 1'b0;
        frc.therm_cool <= 1'b1;
        poll(3'h1, 20);
        frc.bias_low <= 1'b1;
        frc.bias_ok  <= 1'b0;
        poll(3'h0, 20);
        check(32'(outs[1:0]), 32'h0, "gates");
        frc.bias_low <= 1'b0;
        frc.bias_ok  <= 1'b1;
        poll(3'h1, 20);
        summarize();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #(90000 * 25);
        fails++;
        summarize();
    end
endmodule

//--- inc/buck_sup_pkg.sv
package buck_sup_pkg;
    // Switch-cycle timing constants.
    localparam int MIN_ON_NS       = 80;
    localparam int MIN_OFF_NS      = 160;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MIN_ON_CYC      = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_CYC     = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counts in switching cycles; the period is in clock cycles.
    localparam int FB_FAULT_CYC    = 1024;
    localparam int HICCUP_CYC      = 32768;
    localparam int PGOOD_DLY_CYC   = 1024;
    localparam int SS_DEF_CYC      = 4000;
    localparam int PERIOD_DEF_CYC  = 100;

    // Wishbone register offsets.
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STAT   = 8'h04;
    localparam logic [7:0] ADR_IRQST  = 8'h08;
    localparam logic [7:0] ADR_IRQMSK = 8'h0C;
    localparam logic [7:0] ADR_PERIOD = 8'h10;
    localparam logic [7:0] ADR_SSLEN  = 8'h14;

    // Control reset value: converter enabled by software.
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
    localparam logic [31:0] MSK_RST    = 32'h0000_0000;

    // Interrupt bit positions.
    localparam int IRQ_RUNAWAY = 0;
    localparam int IRQ_FBLOW   = 1;
    localparam int IRQ_THERM   = 2;
    localparam int IRQ_PGOOD   = 3;
    localparam int IRQ_W       = 4;

    // Comparator flags from the analog side.
    typedef struct packed {
        logic peak_limit;
        logic runaway_limit;
        logic fb_low;
        logic out_above_95;
        logic out_below_92;
        logic out_above_644;
        logic therm_hot;
        logic therm_cool;
        logic enable_below_falling;
        logic bias_low;
        logic bias_ok;
        logic pwm_on_req;
    } comp_flags_t;

    typedef enum logic [2:0] {
        ST_OFF, ST_SOFTSTART, ST_RUN, ST_HICCUP, ST_THERMAL
    } sup_state_t;
endpackage

//--- logic/buck_fault_hiccup_supervisor.sv
// Functional notes
// - Peak current comparator ends high-side on-time within the same switching cycle.
// - One runaway current event enters hiccup immediately.
// - Feedback low after soft-start enters hiccup 1024 switching cycles later.
// - Hiccup stops switching for 32768 half-frequency switching cycles.
// - Hiccup timeout end starts a fresh soft-start.
// - Retry with low feedback runs half frequency for soft-start plus 1024 cycles.
// - Power-good released after 1024 switching cycles continuously above 95%.
// - Power-good driven low while output below 92%.
// - Power-good driven low in thermal shutdown or enable below falling threshold.
// - Power-good pin only driven low or released; external pull-up gives high.
// - Prebiased start holds both transistors off.
// - Switching begins only on first PWM on-request, then alternates normally.
// - Thermal trip shuts converter down and stops switching.
// - Soft-start held off in thermal shutdown; recovery restarts via soft-start.
// - Start-up switches at half frequency until output reaches 64.4%.
// - Minimum on-time 80ns and minimum off-time 160ns each cycle.
// - Bias supply low forces converter off until it rises above rising threshold; the code restarts once bias_low clears, without waiting for bias_ok.
//
// Local design decisions: the Wishbone slave port and the address map.
module buck_fault_hiccup_supervisor import buck_sup_pkg::*; #(
    parameter int HICCUP_COUNT = HICCUP_CYC
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Wishbone slave.
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Analog comparator flags, asynchronous.
    input  wire comp_flags_t i_flags,
    // Power stage.
    output logic             o_hs_on,
    output logic             o_ls_on,
    output logic             o_softstart_en,
    // Open-drain power-good.
    input  wire logic        i_pgood,
    output logic             o_pgood_out,
    output logic             o_pgood_oe,
    // Interrupt.
    output logic             o_irq
);
    comp_flags_t f;
    sup_state_t  state;
    sup_state_t  next_state;

    logic [31:0] ctrl;
    logic [15:0] period;
    logic [23:0] ss_len;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] phase;
    logic        half_sel;
    logic        active;
    logic        started;
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic [23:0] ss_cnt;
    logic [10:0] fb_cnt;
    logic [15:0] hic_cnt;
    logic [10:0] pg_cnt;
    logic        pgood_rel;
    logic        pgood_rel_d;
    logic        fb_ext;
    logic        pgood_pin;

    // Synchronised comparator flags and power-good pin level.
    sync3 #(.W($bits(comp_flags_t) + 1)) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_pgood, i_flags}),
        .o_sync    ({pgood_pin, f})
    );

    // Saturating increment used by the soft-start cycle counter.
    function automatic logic [23:0] inc_sat(input logic [23:0] v);
        inc_sat = (v == 24'hFF_FFFF) ? v : v + 24'h00_0001;
    endfunction

    // Register bus decode.
    wire        wb_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire        wb_wr    = wb_req & i_wb_we & (i_wb_sel == 4'hF);
    wire        wb_rd    = wb_req & ~i_wb_we;
    wire        rd_irq   = wb_rd & (i_wb_adr == ADR_IRQST);
    wire        sw_en    = ctrl[0];

    // Switching clock: full-rate or half-rate cycle boundary pulse.
    wire        sw_tick  = (phase == 16'h0000);
    wire [15:0] eff_per  = half_sel ? {period[14:0], 1'b0} : period;
    wire [15:0] on_max   = eff_per - 16'(MIN_OFF_CYC);

    // Global shutdown conditions.
    wire        force_off = ~sw_en | f.enable_below_falling | f.bias_low;

    // State transition logic.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (!force_off && (f.bias_ok || !f.bias_low) && !f.therm_hot) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (f.runaway_limit) begin
                    next_state = ST_HICCUP;
                end else if (ss_cnt >= ss_len && fb_ext && f.fb_low && sw_tick) begin
                    next_state = ST_HICCUP;
                end else if (ss_cnt >= ss_len && !f.fb_low) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (f.runaway_limit || (f.fb_low && fb_cnt == 11'(FB_FAULT_CYC))) begin
                    next_state = ST_HICCUP;
                end
            end
            ST_HICCUP: begin
                if (hic_cnt == 16'(HICCUP_COUNT - 1) && sw_tick && half_sel) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_THERMAL: begin
                if (f.therm_cool && !f.therm_hot) begin
                    next_state = ST_SOFTSTART;
                end
            end
        endcase
        if (f.therm_hot) begin
            next_state = ST_THERMAL;
        end else if (force_off) begin
            next_state = ST_OFF;
        end
    end

    // State register.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Switching-cycle phase counter.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || phase >= eff_per - 16'h0001) begin
            phase <= 16'h0000;
        end else begin
            phase <= phase + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            half_sel <= 1'b1;
        end else if (sw_tick) begin
            half_sel <= (state != ST_RUN) && !(state == ST_SOFTSTART && f.out_above_644);
        end
    end

    // Soft-start, feedback and hiccup counters, in switching cycles.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state != ST_SOFTSTART) begin
            ss_cnt <= 24'h00_0000;
            fb_ext <= 1'b0;
        end else if (sw_tick) begin
            ss_cnt <= inc_sat(ss_cnt);
            fb_ext <= (ss_cnt >= ss_len + 24'(FB_FAULT_CYC) - 24'h00_0001);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state != ST_RUN || !f.fb_low) begin
            fb_cnt <= 11'h000;
        end else if (sw_tick && fb_cnt != 11'(FB_FAULT_CYC)) begin
            fb_cnt <= fb_cnt + 11'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state != ST_HICCUP) begin
            hic_cnt <= 16'h0000;
        end else if (sw_tick && half_sel) begin
            hic_cnt <= hic_cnt + 16'h0001;
        end
    end

    // Gate drive: active only in soft-start or run.
    assign active = (state == ST_SOFTSTART) || (state == ST_RUN);

    // prebias hold until first PWM request
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !active) begin
            started <= 1'b0;
        end else if (f.pwm_on_req && sw_tick) begin
            started <= 1'b1;
        end
    end

    // Pulse generator with minimum on and off times.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !active) begin
            o_hs_on <= 1'b0;
            o_ls_on <= 1'b0;
            on_cnt  <= 16'h0000;
            off_cnt <= 16'h0000;
        end else if (o_hs_on) begin
            on_cnt <= on_cnt + 16'h0001;
            if ((f.peak_limit || !f.pwm_on_req || on_cnt >= on_max)
                    && on_cnt >= 16'(MIN_ON_CYC - 1)) begin
                o_hs_on <= 1'b0;
                o_ls_on <= 1'b1;
                off_cnt <= 16'h0000;
            end
        end else begin
            off_cnt <= off_cnt + 16'h0001;
            if (sw_tick && (started || f.pwm_on_req) && f.pwm_on_req && !f.peak_limit
                    && off_cnt >= 16'(MIN_OFF_CYC - 1)) begin
                o_hs_on <= 1'b1;
                o_ls_on <= 1'b0;
                on_cnt  <= 16'h0000;
            end
        end
    end

    // soft-start held off outside active states
    assign o_softstart_en = active;

    wire pg_hold = f.out_below_92 || state == ST_THERMAL || f.therm_hot || f.enable_below_falling;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !f.out_above_95 || pg_hold) begin
            pg_cnt <= 11'h000;
        end else if (sw_tick && pg_cnt != 11'(PGOOD_DLY_CYC)) begin
            pg_cnt <= pg_cnt + 11'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pgood_rel   <= 1'b0;
            pgood_rel_d <= 1'b0;
        end else begin
            pgood_rel   <= !pg_hold && pg_cnt == 11'(PGOOD_DLY_CYC);
            pgood_rel_d <= pgood_rel;
        end
    end

    assign o_pgood_out = 1'b0;
    assign o_pgood_oe  = ~pgood_rel;

    // Register file and sticky interrupts; a read of status clears it, set wins.
    wire [IRQ_W-1:0] irq_ev = {pgood_rel & ~pgood_rel_d,
                               next_state == ST_THERMAL && state != ST_THERMAL,
                               next_state == ST_HICCUP && state == ST_RUN && !f.runaway_limit,
                               f.runaway_limit && active};

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl     <= CTRL_RST;
            irq_mask <= MSK_RST[IRQ_W-1:0];
            period   <= 16'(PERIOD_DEF_CYC);
            ss_len   <= 24'(SS_DEF_CYC);
            irq_stat <= '0;
        end else begin
            irq_stat <= (rd_irq ? '0 : irq_stat) | irq_ev;
            if (wb_wr && i_wb_adr == ADR_CTRL) begin
                ctrl <= i_wb_dat;
            end
            if (wb_wr && i_wb_adr == ADR_IRQMSK) begin
                irq_mask <= i_wb_dat[IRQ_W-1:0];
            end
            if (wb_wr && i_wb_adr == ADR_PERIOD && i_wb_dat[15:0] > 16'(MIN_ON_CYC + MIN_OFF_CYC)) begin
                period <= i_wb_dat[15:0];
            end
            if (wb_wr && i_wb_adr == ADR_SSLEN) begin
                ss_len <= i_wb_dat[23:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero and are acknowledged.
    wire [31:0] rd_mux =
        (i_wb_adr == ADR_CTRL)   ? ctrl :
        (i_wb_adr == ADR_STAT)   ? {24'h00_0000, pgood_pin, pgood_rel, o_ls_on, o_hs_on, half_sel, 3'(state)} :
        (i_wb_adr == ADR_IRQST)  ? {28'h000_0000, irq_stat} :
        (i_wb_adr == ADR_IRQMSK) ? {28'h000_0000, irq_mask} :
        (i_wb_adr == ADR_PERIOD) ? {16'h0000, period} :
        (i_wb_adr == ADR_SSLEN)  ? {8'h00, ss_len} : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= wb_rd ? rd_mux : o_wb_dat;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    // Gate drive never overlaps.
    property p_no_shoot;
        @(posedge i_clk) disable iff (!i_reset_n) !(o_hs_on && o_ls_on);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("gates overlap");

    property p_runaway;
        @(posedge i_clk) disable iff (!i_reset_n)
            (state == ST_RUN && f.runaway_limit && !f.therm_hot && !force_off) |=> state == ST_HICCUP;
    endproperty
    a_runaway: assert property (p_runaway) else $error("runaway did not enter hiccup");

    property p_hic_quiet;
        @(posedge i_clk) disable iff (!i_reset_n) state == ST_HICCUP |=> !o_hs_on;
    endproperty
    a_hic_quiet: assert property (p_hic_quiet) else $error("switching in hiccup");

    property p_therm;
        @(posedge i_clk) disable iff (!i_reset_n) f.therm_hot |=> state == ST_THERMAL && !o_softstart_en;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal not shut down");

    property p_pg_low;
        @(posedge i_clk) disable iff (!i_reset_n) f.out_below_92 |=> ##1 o_pgood_oe;
    endproperty
    a_pg_low: assert property (p_pg_low) else $error("pgood not low");

    property p_pg_rel;
        @(posedge i_clk) disable iff (!i_reset_n) $rose(pgood_rel) |-> $past(pg_cnt) == 11'(PGOOD_DLY_CYC);
    endproperty
    a_pg_rel: assert property (p_pg_rel) else $error("pgood released early");

    property p_prebias;
        @(posedge i_clk) disable iff (!i_reset_n) (active && !started && !f.pwm_on_req) |=> !o_ls_on;
    endproperty
    a_prebias: assert property (p_prebias) else $error("low side on before start");

    property p_min_on;
        @(posedge i_clk) disable iff (!i_reset_n) $rose(o_hs_on) |-> (o_hs_on || !active) [*4];
    endproperty
    a_min_on: assert property (p_min_on) else $error("on-time too short");

    property p_bias;
        @(posedge i_clk) disable iff (!i_reset_n) f.bias_low && !f.therm_hot |=> state == ST_OFF;
    endproperty
    a_bias: assert property (p_bias) else $error("bias low not off");
endmodule

//--- logic/sync3.sv
// Three-stage synchroniser; a change counts once stages two and three agree.
module sync3 import buck_sup_pkg::*; #(
    parameter int W = 12
) (
    // Clock and reset.
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    // Data.
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Shift chain and agreement filter.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s1     <= '0;
            s2     <= '0;
            s3     <= '0;
            o_sync <= '0;
        end else begin
            s1     <= i_async;
            s2     <= s1;
            s3     <= s2;
            o_sync <= (s2 & s3) | (o_sync & (s2 | s3));
        end
    end
endmodule
